// file: core/fdw_defs.vh
// Purpose: constants for the drive fault diagnostic words block
// Assumes: 10 MHz clock, APB byte addresses
// Notes:   definitions only
`ifndef FDW_DEFS_VH
`define FDW_DEFS_VH

// ------------------------------------------------
// register byte offsets
// ------------------------------------------------
`define FDW_A_PROC_EMCY   8'h00
`define FDW_A_FB_DIAG     8'h04
`define FDW_A_TQ_OFF      8'h08
`define FDW_A_STATUS      8'h0c
`define FDW_A_CMD_ERR     8'h10
`define FDW_A_OC_A        8'h14
`define FDW_A_OC_B        8'h18
`define FDW_A_OC_C        8'h1c
`define FDW_A_CTRL        8'h20
`define FDW_A_SM_WD       8'h24
`define FDW_A_SYNC_WD     8'h28
`define FDW_A_SYNC_PER    8'h2c
`define FDW_A_OC_PERSIST  8'h30
`define FDW_A_TRK_WARN    8'h34
`define FDW_A_TRK_FAULT   8'h38
`define FDW_A_PDO_LEN     8'h3c

// ------------------------------------------------
// field positions
// ------------------------------------------------
`define FDW_PE_LONG_LSB   24
`define FDW_FB_SM_WD      0
`define FDW_FB_SYNC_WD    1
`define FDW_FB_PLL        2
`define FDW_FB_SYNC_ERR   3
`define FDW_FB_EE_OLD     9
`define FDW_FB_EE_SCHED   10
`define FDW_FB_EE_FAIL    11
`define FDW_TQ_LOST       0
`define FDW_TQ_MID        1
`define FDW_ST_OC_WARN    0
`define FDW_ST_OC_FAULT   1
`define FDW_ST_TRK_WARN   2
`define FDW_ST_TRK_FAULT  3
`define FDW_ST_CMD_FAIL   4
`define FDW_CT_FRESET     0
`define FDW_CT_TRK_MASK   1

// ------------------------------------------------
// reset values and timing
// ------------------------------------------------
`define FDW_CNT_W         24
`define FDW_RST_CNT       24'h000000
`define FDW_RST_LEN       32'h08080808
`define FDW_RST_OCP       16'h0010
`define FDW_CLK_HZ        10000000
`define FDW_STO_MID_MS    500
`define FDW_SYNC_CAP_MS   1
`define FDW_MS_DIV        1000

`endif

// file: core/fdw_sync3.v
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: asynchronous level input
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module fdw_sync3 (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // level in and out
  input  wire d_in,
  output reg  q_out
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge clk) begin
    if (!rst_n) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      q_out <= 1'b0;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_out <= s3_r;
      end
    end
  end

endmodule

`default_nettype wire

// file: core/fdw_diag.v
// Purpose: fault and warning diagnostic words of a servo drive, APB slave
// Assumes: 10 MHz clk, synchronous active-low reset, event strobes on clk
// Notes:   fault bits sticky until fault reset, warning bits follow condition
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "fdw_defs.vh"

module fdw_diag #(
  parameter STO_MID_CYC  = `FDW_STO_MID_MS * (`FDW_CLK_HZ / `FDW_MS_DIV),
  parameter SYNC_CAP_CYC = `FDW_SYNC_CAP_MS * (`FDW_CLK_HZ / `FDW_MS_DIV)
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // strap: drive carries fieldbus port
  input  wire        fieldbus_drive_variant,
  // fieldbus events
  input  wire [3:0]  pdo_rx_stb,
  input  wire [7:0]  pdo_rx_len,
  input  wire        sync0_stb,
  input  wire        pll_locked,
  input  wire        eeprom_stale,
  input  wire        eeprom_update_sched,
  input  wire        eeprom_update_failed,
  // overcurrent
  input  wire        oc_detect,
  input  wire [15:0] phase_a_current,
  input  wire [15:0] phase_b_current,
  input  wire [15:0] phase_c_current,
  // tracking and system command
  input  wire [15:0] tracking_error,
  input  wire        sys_cmd_done,
  input  wire [15:0] sys_cmd_err,
  // torque-off input pins and drive state
  input  wire        safe_torque_off_input,
  input  wire        sto_mid_range,
  input  wire        drive_enabled,
  input  wire        enable_req
);

  function over;
    input [`FDW_CNT_W-1:0] cnt;
    input [`FDW_CNT_W-1:0] lim;
    begin
      over = (lim != `FDW_RST_CNT) && (cnt >= lim);
    end
  endfunction

  function [`FDW_CNT_W-1:0] inc;
    input [`FDW_CNT_W-1:0] cnt;
    begin
      inc = (&cnt) ? cnt : cnt + 1'b1;
    end
  endfunction

  // ------------------------------------------------
  // state
  // ------------------------------------------------
  reg                  variant_r;
  reg                  captured_r;
  reg [3:0]            pdo_long_r;
  reg [3:0]            fb_fault_r;
  reg [1:0]            tq_fault_r;
  reg                  oc_fault_r;
  reg                  trk_fault_r;
  reg                  trk_warn_r;
  reg                  cmd_fail_r;
  reg [15:0]           cmd_err_r;
  reg [15:0]           oc_a_r;
  reg [15:0]           oc_b_r;
  reg [15:0]           oc_c_r;
  reg                  trk_mask_r;
  reg [`FDW_CNT_W-1:0] sm_wd_lim_r;
  reg [`FDW_CNT_W-1:0] sync_wd_lim_r;
  reg [`FDW_CNT_W-1:0] sync_per_r;
  reg [15:0]           oc_persist_r;
  reg [15:0]           trk_warn_lim_r;
  reg [15:0]           trk_fault_lim_r;
  reg [31:0]           pdo_len_r;
  reg [`FDW_CNT_W-1:0] sm_cnt_r;
  reg [`FDW_CNT_W-1:0] sync_cnt_r;
  reg [`FDW_CNT_W-1:0] phase_cnt_r;
  reg                  pdo_seen_r;
  reg [`FDW_CNT_W-1:0] mid_cnt_r;
  reg [15:0]           oc_cnt_r;
  reg                  sto_prev_r;

  wire sto_ok;
  wire sto_mid;

  fdw_sync3 u_sync_sto (
    .clk   (clk),
    .rst_n (rst_n),
    .d_in  (safe_torque_off_input),
    .q_out (sto_ok)
  );

  fdw_sync3 u_sync_mid (
    .clk   (clk),
    .rst_n (rst_n),
    .d_in  (sto_mid_range),
    .q_out (sto_mid)
  );

  // ------------------------------------------------
  // bus decode
  // ------------------------------------------------
  wire bus_wr   = psel & penable & pready & pwrite;
  wire fault_rs = bus_wr && (paddr == `FDW_A_CTRL) && pwdata[`FDW_CT_FRESET];
  wire pdo_any  = |pdo_rx_stb;
  wire fb_en    = variant_r & captured_r;

  // ------------------------------------------------
  // sync window bounds
  // ------------------------------------------------
  wire [`FDW_CNT_W-1:0] half_per = {1'b0, sync_per_r[`FDW_CNT_W-1:1]};
  wire [`FDW_CNT_W-1:0] hi_half  = sync_per_r + half_per;
  wire [`FDW_CNT_W-1:0] hi_cap   = sync_per_r + SYNC_CAP_CYC[`FDW_CNT_W-1:0];
  wire [`FDW_CNT_W-1:0] hi_win   = (hi_half < hi_cap) ? hi_half : hi_cap;
  wire                  win_on   = (sync_per_r != `FDW_RST_CNT);
  wire pdo_early = win_on && pdo_any && (phase_cnt_r < half_per);
  wire pdo_late  = win_on && (pdo_any || !pdo_seen_r) && (phase_cnt_r > hi_win);

  // ------------------------------------------------
  // event conditions
  // ------------------------------------------------
  wire [3:0] fb_set;
  assign fb_set[`FDW_FB_SM_WD]    = over(sm_cnt_r, sm_wd_lim_r) && !pdo_any;
  assign fb_set[`FDW_FB_SYNC_WD]  = over(sync_cnt_r, sync_wd_lim_r) && !sync0_stb;
  assign fb_set[`FDW_FB_PLL]      = !pll_locked;
  assign fb_set[`FDW_FB_SYNC_ERR] = pdo_early | pdo_late;

  wire [1:0] tq_set;
  // input lost or enable without input
  assign tq_set[`FDW_TQ_LOST] = (drive_enabled && sto_prev_r && !sto_ok) || (enable_req && !sto_ok);
  assign tq_set[`FDW_TQ_MID]  = sto_mid && (mid_cnt_r >= STO_MID_CYC[`FDW_CNT_W-1:0]);

  wire oc_set  = oc_detect && (oc_cnt_r >= oc_persist_r);
  // fault threshold, mask only on fault
  wire trk_set = (tracking_error > trk_fault_lim_r) && !trk_mask_r;

  // ------------------------------------------------
  // strap capture and counters
  // ------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      variant_r   <= 1'b0;
      captured_r  <= 1'b0;
      sm_cnt_r    <= `FDW_RST_CNT;
      sync_cnt_r  <= `FDW_RST_CNT;
      phase_cnt_r <= `FDW_RST_CNT;
      pdo_seen_r  <= 1'b0;
      mid_cnt_r   <= `FDW_RST_CNT;
      oc_cnt_r    <= 16'h0000;
      sto_prev_r  <= 1'b0;
    end else begin
      if (!captured_r) begin
        variant_r  <= fieldbus_drive_variant;
        captured_r <= 1'b1;
      end
      sm_cnt_r   <= pdo_any ? `FDW_RST_CNT : inc(sm_cnt_r);
      sync_cnt_r <= sync0_stb ? `FDW_RST_CNT : inc(sync_cnt_r);
      if (sync0_stb) begin
        phase_cnt_r <= `FDW_RST_CNT;
        pdo_seen_r  <= 1'b0;
      end else begin
        phase_cnt_r <= inc(phase_cnt_r);
        if (pdo_any || pdo_late) begin
          pdo_seen_r <= 1'b1;
        end
      end
      mid_cnt_r  <= sto_mid ? inc(mid_cnt_r) : `FDW_RST_CNT;
      oc_cnt_r   <= oc_detect ? ((&oc_cnt_r) ? oc_cnt_r : oc_cnt_r + 16'h0001) : 16'h0000;
      sto_prev_r <= sto_ok;
    end
  end

  // ------------------------------------------------
  // diagnostic bits
  // ------------------------------------------------
  integer i;
  always @(posedge clk) begin
    if (!rst_n) begin
      pdo_long_r  <= 4'h0;
      fb_fault_r  <= 4'h0;
      tq_fault_r  <= 2'h0;
      oc_fault_r  <= 1'b0;
      trk_fault_r <= 1'b0;
      trk_warn_r  <= 1'b0;
      cmd_fail_r  <= 1'b0;
      cmd_err_r   <= 16'h0000;
      oc_a_r      <= 16'h0000;
      oc_b_r      <= 16'h0000;
      oc_c_r      <= 16'h0000;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (pdo_rx_stb[i]) begin
          pdo_long_r[i] <= (pdo_rx_len > pdo_len_r[i*8 +: 8]);
        end
      end
      fb_fault_r  <= (fault_rs ? 4'h0 : fb_fault_r) | (fb_en ? fb_set : 4'h0);
      tq_fault_r  <= (fault_rs ? 2'h0 : tq_fault_r) | tq_set;
      oc_fault_r  <= (fault_rs ? 1'b0 : oc_fault_r) | oc_set;
      trk_fault_r <= (fault_rs ? 1'b0 : trk_fault_r) | trk_set;
      trk_warn_r  <= (tracking_error > trk_warn_lim_r);
      if (oc_detect) begin
        oc_a_r <= phase_a_current;
        oc_b_r <= phase_b_current;
        oc_c_r <= phase_c_current;
      end
      if (sys_cmd_done) begin
        cmd_fail_r <= (sys_cmd_err != 16'h0000);
        cmd_err_r  <= sys_cmd_err;
      end
    end
  end

  // ------------------------------------------------
  // configuration registers
  // ------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      trk_mask_r      <= 1'b0;
      sm_wd_lim_r     <= `FDW_RST_CNT;
      sync_wd_lim_r   <= `FDW_RST_CNT;
      sync_per_r      <= `FDW_RST_CNT;
      oc_persist_r    <= `FDW_RST_OCP;
      trk_warn_lim_r  <= 16'hffff;
      trk_fault_lim_r <= 16'hffff;
      pdo_len_r       <= `FDW_RST_LEN;
    end else if (bus_wr) begin
      case (paddr)
        `FDW_A_CTRL:       trk_mask_r      <= pwdata[`FDW_CT_TRK_MASK];
        `FDW_A_SM_WD:      sm_wd_lim_r     <= pwdata[`FDW_CNT_W-1:0];
        `FDW_A_SYNC_WD:    sync_wd_lim_r   <= pwdata[`FDW_CNT_W-1:0];
        `FDW_A_SYNC_PER:   sync_per_r      <= pwdata[`FDW_CNT_W-1:0];
        `FDW_A_OC_PERSIST: oc_persist_r    <= pwdata[15:0];
        `FDW_A_TRK_WARN:   trk_warn_lim_r  <= pwdata[15:0];
        `FDW_A_TRK_FAULT:  trk_fault_lim_r <= pwdata[15:0];
        `FDW_A_PDO_LEN:    pdo_len_r       <= pwdata;
        default:           trk_mask_r      <= trk_mask_r;
      endcase
    end
  end

  // ------------------------------------------------
  // read mux
  // ------------------------------------------------
  reg [31:0] rd_nxt;
  reg        hit_nxt;
  always @* begin
    rd_nxt  = 32'h00000000;
    hit_nxt = 1'b1;
    case (paddr)
      `FDW_A_PROC_EMCY: rd_nxt[`FDW_PE_LONG_LSB +: 4] = pdo_long_r;
      `FDW_A_FB_DIAG: begin
        if (fb_en) begin
          rd_nxt[3:0] = fb_fault_r;
          rd_nxt[`FDW_FB_EE_OLD]   = eeprom_stale;
          rd_nxt[`FDW_FB_EE_SCHED] = eeprom_update_sched;
          rd_nxt[`FDW_FB_EE_FAIL]  = eeprom_update_failed;
        end
      end
      `FDW_A_TQ_OFF: rd_nxt[1:0] = tq_fault_r;
      `FDW_A_STATUS: begin
        rd_nxt[`FDW_ST_OC_WARN]   = oc_detect;
        rd_nxt[`FDW_ST_OC_FAULT]  = oc_fault_r;
        rd_nxt[`FDW_ST_TRK_WARN]  = trk_warn_r;
        rd_nxt[`FDW_ST_TRK_FAULT] = trk_fault_r;
        rd_nxt[`FDW_ST_CMD_FAIL]  = cmd_fail_r;
      end
      `FDW_A_CMD_ERR:     rd_nxt[15:0] = cmd_err_r;
      `FDW_A_OC_A:        rd_nxt[15:0] = oc_a_r;
      `FDW_A_OC_B:        rd_nxt[15:0] = oc_b_r;
      `FDW_A_OC_C:        rd_nxt[15:0] = oc_c_r;
      `FDW_A_CTRL:        rd_nxt[`FDW_CT_TRK_MASK] = trk_mask_r;
      `FDW_A_SM_WD:       rd_nxt[`FDW_CNT_W-1:0] = sm_wd_lim_r;
      `FDW_A_SYNC_WD:     rd_nxt[`FDW_CNT_W-1:0] = sync_wd_lim_r;
      `FDW_A_SYNC_PER:    rd_nxt[`FDW_CNT_W-1:0] = sync_per_r;
      `FDW_A_OC_PERSIST:  rd_nxt[15:0] = oc_persist_r;
      `FDW_A_TRK_WARN:    rd_nxt[15:0] = trk_warn_lim_r;
      `FDW_A_TRK_FAULT:   rd_nxt[15:0] = trk_fault_lim_r;
      `FDW_A_PDO_LEN:     rd_nxt = pdo_len_r;
      default:            hit_nxt = 1'b0;
    endcase
  end

  // ------------------------------------------------
  // apb answer, one wait state
  // ------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata  <= pwrite ? 32'h00000000 : rd_nxt;
        pslverr <= ~hit_nxt;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// file: verification/fdw_diag_props.sv
// Purpose: port-level checks on fdw_diag
// Assumes: one apb wait state, sync active-low reset
// Notes:   bound to every fdw_diag instance
`timescale 1ns/1ps
`default_nettype none

module fdw_diag_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // apb and strap
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        fieldbus_drive_variant
);
  wire logic rd = pready && !pwrite;

  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ready_timing: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready not a single pulse after one wait");
  a_no_setup_ready: assert property (psel && !penable |=> !pready)
    else $error("pready in access cycle one");
  a_unmapped_err: assert property (pready && paddr > 8'h3c |-> pslverr)
    else $error("no pslverr on unmapped address");
  a_mapped_ok: assert property (pready && paddr <= 8'h3c && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("pslverr on mapped address");
  a_err_reads_zero: assert property (rd && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_emcy_reserved: assert property (rd && paddr == 8'h00 |-> prdata[23:0] == 24'h0 && prdata[31:28] == 4'h0)
    else $error("emergency word reserved bits set");
  a_fb_reserved: assert property (rd && paddr == 8'h04 |-> prdata[31:12] == 20'h0 && prdata[8:4] == 5'h0)
    else $error("fieldbus word reserved bits set");
  a_fb_variant: assert property (rd && paddr == 8'h04 && !fieldbus_drive_variant |-> prdata == 32'h0)
    else $error("fieldbus word on plain variant");
  a_tq_reserved: assert property (rd && paddr == 8'h08 |-> prdata[31:2] == 30'h0)
    else $error("torque-off word reserved bits set");
  a_ctrl_reset_bit: assert property (rd && paddr == 8'h20 |-> prdata[0] == 1'b0 && prdata[31:2] == 30'h0)
    else $error("ctrl reads back reset bit");
endmodule

bind fdw_diag fdw_diag_props i_fdw_diag_props (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .fieldbus_drive_variant(fieldbus_drive_variant));
`default_nettype wire

// file: verification/fdw_fb_master.sv
// Purpose: fieldbus master model, sync0 and pdo traffic
// Assumes: period and offset in clk cycles
// Notes:   pdo length line toggles when idle
`timescale 1ns/1ps
`default_nettype none

module fdw_fb_master (
  // clock
  input  wire logic       clk,
  // traffic settings
  input  wire logic       run,
  input  wire logic [7:0] per,
  input  wire logic [7:0] ofs,
  input  wire logic [3:0] sel,
  input  wire logic [7:0] len,
  // toward the block
  output var  logic [3:0] pdo_stb,
  output var  logic [7:0] pdo_len,
  output var  logic       sync_stb
);
  logic [7:0] c_r = 8'h00;

  initial begin
    pdo_stb = 4'h0;
    pdo_len = 8'h00;
    sync_stb = 1'b0;
  end

  always @(posedge clk) begin
    c_r <= (!run || c_r >= per - 8'h01) ? 8'h00 : c_r + 8'h01;
    sync_stb <= run && c_r == 8'h00;
    pdo_stb <= (run && c_r == ofs) ? sel : 4'h0;
    pdo_len <= (run && c_r == ofs) ? len : ~pdo_len;
  end
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Purpose: self-checking bench for fdw_diag
// Assumes: short timing parameters, apb master
// Notes:   scenarios run in one sequence
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, variant, sync0, pll;
  logic        ee_old, ee_sch, ee_bad, oc, cdone, sto, mid, en, ereq, m_run, rd_e;
  logic [7:0]  paddr, plen, m_per, m_ofs, m_len;
  logic [3:0]  pstb, m_sel;
  logic [31:0] pwdata, prdata, rd_d;
  logic [15:0] ia, ib, ic, trk, cerr;
  int          err_total = 0;
  int          total_checks = 0;
  int          cyc = 0;

  fdw_diag #(.STO_MID_CYC(20), .SYNC_CAP_CYC(8)) i_fdw_diag (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fieldbus_drive_variant(variant), .pdo_rx_stb(pstb), .pdo_rx_len(plen), .sync0_stb(sync0),
    .pll_locked(pll), .eeprom_stale(ee_old), .eeprom_update_sched(ee_sch),
    .eeprom_update_failed(ee_bad), .oc_detect(oc), .phase_a_current(ia), .phase_b_current(ib),
    .phase_c_current(ic), .tracking_error(trk), .sys_cmd_done(cdone), .sys_cmd_err(cerr),
    .safe_torque_off_input(sto), .sto_mid_range(mid), .drive_enabled(en), .enable_req(ereq));
  fdw_fb_master i_fdw_fb_master (.clk(clk), .run(m_run), .per(m_per), .ofs(m_ofs),
    .sel(m_sel), .len(m_len), .pdo_stb(pstb), .pdo_len(plen), .sync_stb(sync0));

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_d = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(exp, rd_d);
  endtask
  task automatic fres;
    bus(1'b1, 8'h20, 32'h1);
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic s_regs;
    rc(8'h3c, 32'h08080808);
    rc(8'h30, 32'h10);
    rc(8'h34, 32'hffff);
    bus(1'b1, 8'h00, 32'hffffffff);
    rc(8'h00, 32'h0);
    rc(8'h40, 32'h0);
    chk(32'h1, {31'h0, rd_e});
  endtask
  task automatic s_pdo;
    m_len <= 8'h09;
    m_per <= 8'd20;
    m_ofs <= 8'd3;
    m_run <= 1'b1;
    for (int n = 0; n < 4; n++) begin
      m_sel <= 4'h1 << n;
      w(30);
      rc(8'h00, ((32'h2 << n) - 32'h1) << 24);
    end
    m_sel <= 4'hf;
    m_len <= 8'h08;
    w(30);
    rc(8'h00, 32'h0);
  endtask
  task automatic s_fb;
    bus(1'b1, 8'h24, 32'd50);
    bus(1'b1, 8'h28, 32'd50);
    w(60);
    rc(8'h04, 32'h0);
    m_run <= 1'b0;
    w(60);
    rc(8'h04, 32'h3);
    bus(1'b1, 8'h24, 32'h0);
    bus(1'b1, 8'h28, 32'h0);
    fres;
    rc(8'h04, 32'h0);
    m_per <= 8'd40;
    m_ofs <= 8'd25;
    m_run <= 1'b1;
    bus(1'b1, 8'h2c, 32'd40);
    w(100);
    fres;
    w(100);
    rc(8'h04, 32'h0);
    m_ofs <= 8'd5;
    w(100);
    rc(8'h04, 32'h8);
    pll <= 1'b0;
    w(2);
    pll <= 1'b1;
    rc(8'h04, 32'hc);
    m_run <= 1'b0;
    bus(1'b1, 8'h2c, 32'h0);
    fres;
    for (int i = 0; i < 3; i++) begin
      {ee_bad, ee_sch, ee_old} <= 3'h1 << i;
      w(2);
      rc(8'h04, 32'h200 << i);
    end
    {ee_bad, ee_sch, ee_old} <= 3'h0;
    w(2);
    rc(8'h04, 32'h0);
  endtask
  task automatic s_oc;
    bus(1'b1, 8'h30, 32'd20);
    ia <= 16'h0a11;
    ib <= 16'h0b22;
    ic <= 16'h0c33;
    oc <= 1'b1;
    w(3);
    rc(8'h0c, 32'h1);
    oc <= 1'b0;
    w(3);
    rc(8'h0c, 32'h0);
    rc(8'h14, 32'h0a11);
    rc(8'h18, 32'h0b22);
    rc(8'h1c, 32'h0c33);
    oc <= 1'b1;
    w(30);
    oc <= 1'b0;
    w(3);
    rc(8'h0c, 32'h2);
    w(8); // settle before fault reset, scaled down
    fres;
    rc(8'h0c, 32'h0);
  endtask
  task automatic s_trk;
    bus(1'b1, 8'h34, 32'd100);
    bus(1'b1, 8'h38, 32'd200);
    trk <= 16'd100;
    w(3);
    rc(8'h0c, 32'h0);
    trk <= 16'd250;
    w(3);
    rc(8'h0c, 32'hc);
    // mask first: a set in the reset cycle would win
    bus(1'b1, 8'h20, 32'h2);
    bus(1'b1, 8'h20, 32'h3);
    rc(8'h0c, 32'h4);
    rc(8'h20, 32'h2);
    trk <= 16'd0;
    bus(1'b1, 8'h20, 32'h1);
    rc(8'h0c, 32'h0);
  endtask
  task automatic cmd(input logic [15:0] e);
    cerr <= e;
    cdone <= 1'b1;
    @(posedge clk);
    cdone <= 1'b0;
    w(2);
  endtask
  task automatic s_cmd;
    cmd(16'h0055);
    rc(8'h0c, 32'h10);
    rc(8'h10, 32'h55);
    cmd(16'h0000);
    rc(8'h0c, 32'h0);
  endtask
  task automatic s_sto;
    en <= 1'b1;
    w(8);
    sto <= 1'b0;
    w(8);
    rc(8'h08, 32'h1);
    en <= 1'b0;
    fres;
    rc(8'h08, 32'h0);
    ereq <= 1'b1;
    @(posedge clk);
    ereq <= 1'b0;
    w(3);
    rc(8'h08, 32'h1);
    sto <= 1'b1;
    w(8);
    fres;
    mid <= 1'b1;
    w(10);
    mid <= 1'b0;
    w(8);
    rc(8'h08, 32'h0);
    mid <= 1'b1;
    w(30);
    mid <= 1'b0;
    w(8);
    rc(8'h08, 32'h2);
    fres;
    sto <= 1'b0;
    w(8);
    rc(8'h08, 32'h0);
    sto <= 1'b1;
    w(8);
  endtask
  task automatic s_variant;
    rst_n <= 1'b0;
    variant <= 1'b0;
    pll <= 1'b0;
    w(4);
    rst_n <= 1'b1;
    w(4);
    rc(8'h04, 32'h0);
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_total++;
      tally_and_finish;
    end
  end
  initial begin
    {rst_n, psel, penable, pwrite, cdone, ereq, oc, mid, en, m_run, ee_old, ee_sch, ee_bad} = '0;
    {variant, pll, sto} = 3'h7;
    {paddr, pwdata, ia, ib, ic, trk, cerr, m_per, m_ofs, m_sel, m_len} = '0;
    w(16);
    rst_n <= 1'b1;
    w(1);
    s_regs;
    s_pdo;
    s_fb;
    s_oc;
    s_trk;
    s_cmd;
    s_sto;
    s_variant;
    tally_and_finish;
  end
endmodule
`default_nettype wire
